/* File: design/slp_status_led.sv */
// Design decisions made here: the register addresses and the APB register port.
`timescale 1ns/1ps

// one pattern sequencer for one indicator
module slp_pattern_unit (
   input wire logic i_clk,
   input wire logic i_rst,
   input wire logic i_tick,
   input slp_pkg::slp_pat_t i_pat,
   output logic o_lit
);
   import slp_pkg::*;

   slp_pat_t pat_r;
   logic [5:0] step_r;
   logic [5:0] step_nxt;

   // step counter restarts whenever the selection changes
   always_comb begin
      step_nxt = step_r;
      if (i_pat != pat_r) begin
         step_nxt = 6'h00;
      end else if (i_tick) begin
         if (step_r >= slp_len(pat_r) - 6'h01) begin
            step_nxt = 6'h00;
         end else begin
            step_nxt = step_r + 6'h01;
         end
      end
   end

   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         pat_r <= PAT_OFF;
         step_r <= 6'h00;
      end else begin
         pat_r <= i_pat;
         step_r <= step_nxt;
      end
   end

   // output registered from the next step, so no glitch on restart
   always_ff @(posedge i_clk or posedge i_rst) begin
      if (i_rst) begin
         o_lit <= 1'b0;
      end else begin
         o_lit <= slp_lit(i_pat, step_nxt);
      end
   end
endmodule : slp_pattern_unit

module slp_status_led #(
   parameter int unsigned TICK_CYC = slp_pkg::STEP_CYC,
   parameter int unsigned N_CH = 2
) (
   input wire logic I_SYS_CLK,
   input wire logic I_RST,
   input wire logic I_PSEL,
   input wire logic I_PENABLE,
   input wire logic I_PWRITE,
   input wire logic [11:0] I_PADDR,
   input wire logic [31:0] I_PWDATA,
   input wire logic [3:0] I_PSTRB,
   output logic [31:0] O_PRDATA,
   output logic O_PREADY,
   output logic O_PSLVERR,
   input wire logic [N_CH-1:0] I_LINK,
   input wire logic [N_CH-1:0] I_ACT,
   output logic O_SYS_GREEN,
   output logic O_SYS_YELLOW,
   output logic O_APP_GREEN,
   output logic O_APP_RED,
   output logic O_RUN_LED,
   output logic O_ERR_LED,
   output logic [N_CH-1:0] O_LINK_ACT
);
   import slp_pkg::*;

   // the status register holds two bits per channel
   generate
      if (TICK_CYC < 2 || N_CH != 2) begin : g_chk
         $error("slp_status_led: TICK_CYC >= 2 and N_CH == 2");
      end
   endgenerate

   logic [31:0] ctrl_r;
   slp_ctrl_t ctrl;
   slp_stat_t stat;
   logic [31:0] tick_cnt_r;
   logic tick_r;
   logic [N_CH-1:0] link_m_r;
   logic [N_CH-1:0] link_r;
   logic [N_CH-1:0] act_m_r;
   logic [N_CH-1:0] act_r;
   logic [N_CH-1:0] act_busy;
   logic [N_CH-1:0] la_lit;
   logic run_lit;
   logic err_lit;
   logic app_lit;
   logic app_red_sel;
   logic sys_lit;
   slp_pat_t run_pat;
   slp_pat_t err_pat;
   slp_pat_t app_pat;
   slp_pat_t sys_pat;
   logic apb_acc;
   logic addr_ok;
   logic [31:0] rd_val;
   logic [31:0] wr_val;

   assign ctrl = slp_ctrl_t'(ctrl_r[23:0]);

   // single step tick shared by every indicator
   always_ff @(posedge I_SYS_CLK or posedge I_RST) begin
      if (I_RST) begin
         tick_cnt_r <= 32'h0000_0000;
         tick_r <= 1'b0;
      end else if (tick_cnt_r >= TICK_CYC - 1) begin
         tick_cnt_r <= 32'h0000_0000;
         tick_r <= 1'b1;
      end else begin
         tick_cnt_r <= tick_cnt_r + 32'h0000_0001;
         tick_r <= 1'b0;
      end
   end

   // pins from the phy are asynchronous: two stages each
   always_ff @(posedge I_SYS_CLK or posedge I_RST) begin
      if (I_RST) begin
         link_m_r <= '0;
         link_r <= '0;
         act_m_r <= '0;
         act_r <= '0;
      end else begin
         link_m_r <= I_LINK;
         link_r <= link_m_r;
         act_m_r <= I_ACT;
         act_r <= act_m_r;
      end
   end

   // run indicator follows the slave state machine
   always_comb begin
      case (ctrl.run_state)
         RUN_PREOP: run_pat = PAT_BLINK;
         RUN_SAFEOP: run_pat = PAT_SINGLE;
         RUN_OP: run_pat = PAT_ON;
         default: run_pat = PAT_OFF;
      endcase
   end

   // error indicator: steady first, then by severity
   always_comb begin
      if (ctrl.iface_wd) begin
         err_pat = PAT_ON;
      end else if (ctrl.app_wd) begin
         err_pat = PAT_DOUBLE;
      end else if (ctrl.layer_change == LAYER_CHANGE_ERR) begin
         err_pat = PAT_SINGLE;
      end else if (ctrl.cfg_err) begin
         err_pat = PAT_BLINK;
      end else begin
         err_pat = PAT_OFF;
      end
   end

   // application indicator: pattern and colour together
   always_comb begin
      app_pat = PAT_OFF;
      app_red_sel = 1'b0;
      if (ctrl.init_err) begin
         app_pat = PAT_ON;
         app_red_sel = 1'b1;
      end else if (ctrl.cyclic_ok) begin
         app_pat = PAT_ON;
      end else if (ctrl.init_done) begin
         // configuration faults outrank missing data exchange
         if (ctrl.p1_cfg_err) begin
            app_pat = PAT_SLOW1;
            app_red_sel = 1'b1;
         end else if (ctrl.p2_cfg_err) begin
            app_pat = PAT_SLOW2;
            app_red_sel = 1'b1;
         end else if (ctrl.p1_no_cyclic) begin
            app_pat = PAT_SLOW1;
         end else if (ctrl.p2_no_cyclic) begin
            app_pat = PAT_SLOW2;
         end
      end
   end

   // system indicator: while booting, lit phase shows yellow, dark phase green
   always_comb begin
      if (ctrl.boot_active) begin
         sys_pat = PAT_BLINK;
      end else begin
         sys_pat = PAT_ON;
      end
   end

   slp_pattern_unit u_run (
      .i_clk(I_SYS_CLK),
      .i_rst(I_RST),
      .i_tick(tick_r),
      .i_pat(run_pat),
      .o_lit(run_lit)
   );

   slp_pattern_unit u_err (
      .i_clk(I_SYS_CLK),
      .i_rst(I_RST),
      .i_tick(tick_r),
      .i_pat(err_pat),
      .o_lit(err_lit)
   );

   slp_pattern_unit u_app (
      .i_clk(I_SYS_CLK),
      .i_rst(I_RST),
      .i_tick(tick_r),
      .i_pat(app_pat),
      .o_lit(app_lit)
   );

   slp_pattern_unit u_sys (
      .i_clk(I_SYS_CLK),
      .i_rst(I_RST),
      .i_tick(tick_r),
      .i_pat(sys_pat),
      .o_lit(sys_lit)
   );

   // per channel link/activity; activity is stretched in ticks
   generate
      for (genvar c = 0; c < N_CH; c++) begin : g_ch
         logic [2:0] hold_r;
         slp_pat_t la_pat;

         always_ff @(posedge I_SYS_CLK or posedge I_RST) begin
            if (I_RST) begin
               hold_r <= 3'h0;
            end else if (act_r[c] && link_r[c]) begin
               hold_r <= ACT_HOLD;
            end else if (tick_r && hold_r != 3'h0) begin
               hold_r <= hold_r - 3'h1;
            end
         end

         assign act_busy[c] = (hold_r != 3'h0);

         always_comb begin
            if (!link_r[c]) begin
               la_pat = PAT_OFF;
            end else if (act_busy[c]) begin
               la_pat = PAT_BLINK;
            end else begin
               la_pat = PAT_ON;
            end
         end

         slp_pattern_unit u_la (
            .i_clk(I_SYS_CLK),
            .i_rst(I_RST),
            .i_tick(tick_r),
            .i_pat(la_pat),
            .o_lit(la_lit[c])
         );
      end
   endgenerate

   // pin drivers, one flop stage after the sequencers
   always_ff @(posedge I_SYS_CLK or posedge I_RST) begin
      if (I_RST) begin
         O_RUN_LED <= 1'b0;
         O_ERR_LED <= 1'b0;
         O_APP_GREEN <= 1'b0;
         O_APP_RED <= 1'b0;
         O_SYS_GREEN <= 1'b0;
         O_SYS_YELLOW <= 1'b0;
         O_LINK_ACT <= '0;
      end else begin
         O_RUN_LED <= run_lit;
         O_ERR_LED <= err_lit;
         O_APP_GREEN <= app_lit && !app_red_sel;
         O_APP_RED <= app_lit && app_red_sel;
         // yellow until firmware reports start: startup only
         if (ctrl.boot_active) begin
            O_SYS_YELLOW <= sys_lit;
            O_SYS_GREEN <= !sys_lit;
         end else begin
            O_SYS_YELLOW <= !ctrl.fw_started;
            O_SYS_GREEN <= ctrl.fw_started;
         end
         O_LINK_ACT <= la_lit;
      end
   end

   // apb slave: one wait state, answer registered
   assign apb_acc = I_PSEL && I_PENABLE;
   assign addr_ok = (I_PADDR == ADDR_CTRL) || (I_PADDR == ADDR_STAT);

   assign stat.sys_yellow = O_SYS_YELLOW;
   assign stat.sys_green = O_SYS_GREEN;
   assign stat.app_red = O_APP_RED;
   assign stat.app_green = O_APP_GREEN;
   assign stat.err = O_ERR_LED;
   assign stat.run = O_RUN_LED;
   assign stat.act = act_busy;
   assign stat.link = link_r;

   always_comb begin
      rd_val = 32'h0000_0000;
      if (I_PADDR == ADDR_CTRL) begin
         rd_val = ctrl_r;
      end else if (I_PADDR == ADDR_STAT) begin
         rd_val = {22'h00_0000, stat};
      end
   end

   // byte strobes merge into the stored word; reserved bits stay 0
   always_comb begin
      wr_val = ctrl_r;
      for (int b = 0; b < 4; b++) begin
         if (I_PSTRB[b]) begin
            wr_val[8*b +: 8] = I_PWDATA[8*b +: 8];
         end
      end
      wr_val = wr_val & CTRL_MASK;
   end

   always_ff @(posedge I_SYS_CLK or posedge I_RST) begin
      if (I_RST) begin
         O_PREADY <= 1'b0;
         O_PRDATA <= 32'h0000_0000;
         O_PSLVERR <= 1'b0;
      end else if (apb_acc && !O_PREADY) begin
         O_PREADY <= 1'b1;
         O_PRDATA <= I_PWRITE ? 32'h0000_0000 : rd_val;
         O_PSLVERR <= !addr_ok;
      end else begin
         O_PREADY <= 1'b0;
         O_PRDATA <= 32'h0000_0000;
         O_PSLVERR <= 1'b0;
      end
   end

   // write lands on the edge where pready is seen high
   always_ff @(posedge I_SYS_CLK or posedge I_RST) begin
      if (I_RST) begin
         ctrl_r <= CTRL_RST;
      end else if (apb_acc && O_PREADY && I_PWRITE &&
                   I_PADDR == ADDR_CTRL) begin
         ctrl_r <= wr_val;
      end
   end
endmodule : slp_status_led

/* File: design/slp_pkg.sv */
package slp_pkg;
   // clock and pattern time base
   localparam int unsigned CLK_HZ = 50_000_000;
   localparam int unsigned STEP_MS = 100;
   localparam int unsigned STEP_CYC = CLK_HZ / 1000 * STEP_MS;
   // one phase of the 200 ms patterns, in steps
   localparam int unsigned PHASE_MS = 200;
   localparam int unsigned PHASE_STEPS = PHASE_MS / STEP_MS;
   // activity stretch so short frames still show a flash
   localparam logic [2:0] ACT_HOLD = 3'h4;

   // pattern step windows, in 100 ms steps
   localparam logic [5:0] BLINK_ON = 6'h02;
   localparam logic [5:0] BLINK_LEN = 6'h04;
   localparam logic [5:0] SGL_LEN = 6'h0c;
   localparam logic [5:0] DBL_ON2 = 6'h04;
   localparam logic [5:0] DBL_OFF2 = 6'h06;
   localparam logic [5:0] DBL_LEN = 6'h10;
   localparam logic [5:0] SLOW_ON = 6'h14;
   localparam logic [5:0] SLOW_OFF = 6'h19;
   localparam logic [5:0] SLOW1_LEN = 6'h19;
   localparam logic [5:0] SLOW_ON2 = 6'h1e;
   localparam logic [5:0] SLOW2_LEN = 6'h23;

   // register map
   localparam logic [11:0] ADDR_CTRL = 12'h000;
   localparam logic [11:0] ADDR_STAT = 12'h004;
   localparam logic [31:0] CTRL_RST = 32'h0000_0000;
   localparam logic [31:0] CTRL_MASK = 32'h00ff_7ffb;
   localparam logic [7:0] LAYER_CHANGE_ERR = 8'h01;

   // slave state machine states as firmware reports them
   localparam logic [1:0] RUN_INIT = 2'h0;
   localparam logic [1:0] RUN_PREOP = 2'h1;
   localparam logic [1:0] RUN_SAFEOP = 2'h2;
   localparam logic [1:0] RUN_OP = 2'h3;

   typedef struct packed {
      logic [7:0] layer_change;
      logic rsv_hi;
      logic init_err;
      logic p2_cfg_err;
      logic p1_cfg_err;
      logic p2_no_cyclic;
      logic p1_no_cyclic;
      logic init_done;
      logic cyclic_ok;
      logic fw_started;
      logic boot_active;
      logic iface_wd;
      logic app_wd;
      logic cfg_err;
      logic rsv_lo;
      logic [1:0] run_state;
   } slp_ctrl_t;

   typedef struct packed {
      logic sys_yellow;
      logic sys_green;
      logic app_red;
      logic app_green;
      logic err;
      logic run;
      logic [1:0] act;
      logic [1:0] link;
   } slp_stat_t;

   typedef enum {
      PAT_OFF, PAT_ON, PAT_BLINK, PAT_SINGLE, PAT_DOUBLE,
      PAT_SLOW1, PAT_SLOW2
   } slp_pat_t;

   // length of one pattern cycle in steps
   function automatic logic [5:0] slp_len(slp_pat_t p);
      case (p)
         PAT_BLINK: slp_len = BLINK_LEN;
         PAT_SINGLE: slp_len = SGL_LEN;
         PAT_DOUBLE: slp_len = DBL_LEN;
         PAT_SLOW1: slp_len = SLOW1_LEN;
         PAT_SLOW2: slp_len = SLOW2_LEN;
         default: slp_len = 6'h01;
      endcase
   endfunction : slp_len

   // indicator level for a pattern at a given step
   function automatic logic slp_lit(slp_pat_t p, logic [5:0] s);
      case (p)
         PAT_ON: slp_lit = 1'b1;
         PAT_BLINK: slp_lit = (s < BLINK_ON);
         PAT_SINGLE: slp_lit = (s < BLINK_ON);
         PAT_DOUBLE: slp_lit = (s < BLINK_ON) ||
            (s >= DBL_ON2 && s < DBL_OFF2);
         PAT_SLOW1: slp_lit = (s >= SLOW_ON);
         PAT_SLOW2: slp_lit = (s >= SLOW_ON && s < SLOW_OFF) ||
            (s >= SLOW_ON2);
         default: slp_lit = 1'b0;
      endcase
   endfunction : slp_lit
endpackage : slp_pkg

/* File: testbench/slp_status_led_props.sv */
`timescale 1ns/1ps
// port-level checks beside the status indicator block
module slp_props #(
   parameter int unsigned N_CH = 2
) (
   input wire logic I_SYS_CLK,
   input wire logic I_RST,
   input wire logic I_PSEL,
   input wire logic I_PENABLE,
   input wire logic I_PWRITE,
   input wire logic [11:0] I_PADDR,
   input wire logic [31:0] I_PWDATA,
   input wire logic [3:0] I_PSTRB,
   input wire logic [31:0] O_PRDATA,
   input wire logic O_PREADY,
   input wire logic O_PSLVERR,
   input wire logic [N_CH-1:0] I_LINK,
   input wire logic O_APP_GREEN,
   input wire logic O_APP_RED,
   input wire logic O_RUN_LED,
   input wire logic O_ERR_LED,
   input wire logic [N_CH-1:0] O_LINK_ACT
);
   default clocking cb @(posedge I_SYS_CLK);
   endclocking
   default disable iff (I_RST);
   // access phase right after a setup cycle
   sequence setup_access;
      (I_PSEL && !I_PENABLE) ##1 (I_PSEL && I_PENABLE);
   endsequence
   // completed control write that carries byte 0
   sequence ctrl_wr(b);
      I_PSEL && I_PENABLE && O_PREADY && I_PWRITE &&
         I_PADDR == 12'h000 && I_PSTRB[0] && b;
   endsequence
   a_one_wait: assert property (setup_access |->
      !O_PREADY ##1 O_PREADY) else $error("ready not after one wait");
   a_ready_pulse: assert property (O_PREADY |=> !O_PREADY)
      else $error("ready longer than one cycle");
   a_idle_data: assert property (!O_PREADY |-> O_PRDATA == 32'h0)
      else $error("read data outside ready");
   a_err_decode: assert property (O_PREADY |-> O_PSLVERR ==
      (I_PADDR != 12'h000 && I_PADDR != 12'h004))
      else $error("slave error decode wrong");
   a_app_excl: assert property (!(O_APP_GREEN && O_APP_RED))
      else $error("application red and green together");
   a_link_dark: assert property (!I_LINK[0] [*6] |-> !O_LINK_ACT[0])
      else $error("link indicator lit without link");
   a_init_dark: assert property (
      ctrl_wr(I_PWDATA[1:0] == 2'h0) |-> ##3 !O_RUN_LED [*2])
      else $error("run indicator lit in init");
   a_op_lit: assert property (
      ctrl_wr(I_PWDATA[1:0] == 2'h3) |-> ##3 O_RUN_LED [*2])
      else $error("run indicator not steady");
   a_iface_lit: assert property (
      ctrl_wr(I_PWDATA[5]) |-> ##3 O_ERR_LED [*2])
      else $error("error indicator not steady");
endmodule : slp_props

bind slp_status_led slp_props #(.N_CH(N_CH)) slp_props_inst (.*);

/* File: testbench/slp_led_eye.sv */
`timescale 1ns/1ps
// operator's eye: counts lit cycles and turn-ons while watching
module slp_led_eye (
   input wire logic i_clk,
   input wire logic i_led,
   input wire logic i_en,
   output integer o_lit,
   output integer o_rises
);
   logic prev_r = 1'b0;
   // window restarts whenever watching stops
   always @(posedge i_clk) begin
      prev_r <= i_led;
      if (!i_en) begin
         o_lit <= 0;
         o_rises <= 0;
      end else begin
         // four-state sums: an unknown pin level shows up as a mismatch
         o_lit <= o_lit + i_led;
         o_rises <= o_rises + (i_led && !prev_r);
      end
   end
endmodule : slp_led_eye

/* File: testbench/tb_top.sv */
`timescale 1ns/1ps
// bench: rule model compared with the block
module tb_top;
   import slp_pkg::*;
   localparam int T = 10;
   localparam int LIMIT = 90000; // about three and a half times the worst run
   logic I_SYS_CLK = 1'b0;
   logic I_RST = 1'b1;
   logic I_PSEL = 1'b0;
   logic I_PENABLE = 1'b0;
   logic I_PWRITE = 1'b0;
   logic [11:0] I_PADDR = 12'h000;
   logic [31:0] I_PWDATA = 32'h0;
   logic [3:0] I_PSTRB = 4'h0;
   logic [1:0] I_LINK = 2'h0;
   logic [1:0] I_ACT = 2'h0;
   logic [31:0] O_PRDATA;
   logic O_PREADY, O_PSLVERR, O_SYS_GREEN, O_SYS_YELLOW;
   logic O_APP_GREEN, O_APP_RED, O_RUN_LED, O_ERR_LED;
   logic [1:0] O_LINK_ACT;
   logic [7:0] leds;
   logic obs_en = 1'b0;
   logic [31:0] ctrl_m = 32'h0;
   int sel = 0;
   integer obs_lit, obs_rises;
   int failures = 0, tests_run = 0, cyc = 0;
   int seed = 32'h0a09;
   // per pattern, in steps: period, lit steps, turn-ons
   int per_s[7] = '{1, 1, 4, 12, 16, 25, 35};
   int lit_s[7] = '{0, 1, 2, 2, 4, 5, 10};
   int ris_s[7] = '{0, 0, 1, 1, 2, 1, 2};
   // directed control words, random ones follow
   logic [31:0] dir[$] = '{32'h0, 32'h1, 32'h2, 32'h3, 32'h8,
      32'h1_0000, 32'h10, 32'h20, 32'h38, 32'h1_0008, 32'h4100,
      32'h100, 32'h600, 32'ha00, 32'h1200, 32'h2200, 32'h1600,
      32'h40, 32'h80, 32'h2_0000};

   always #10 I_SYS_CLK = ~I_SYS_CLK;
   assign leds = {O_LINK_ACT, O_SYS_YELLOW, O_SYS_GREEN, O_APP_RED,
      O_APP_GREEN, O_ERR_LED, O_RUN_LED};

   slp_status_led #(.TICK_CYC(T), .N_CH(2)) slp_status_led_inst (.*);
   slp_led_eye slp_led_eye_inst (.i_clk(I_SYS_CLK), .i_led(leds[sel]),
      .i_en(obs_en), .o_lit(obs_lit), .o_rises(obs_rises));

   // expected pattern of one indicator: 0 off 1 on 2 blink 3 single
   // 4 double 5 one slow pulse 6 two slow pulses
   function automatic int model(logic [31:0] c, logic [1:0] lk,
      logic [1:0] ac, int k);
      case (k)
         0: return c[1:0] == 2'h0 ? 0 : c[1:0] == 2'h1 ? 2 :
            c[1:0] == 2'h2 ? 3 : 1;
         1: return c[5] ? 1 : c[4] ? 4 : c[23:16] == 8'h01 ? 3 :
            c[3] ? 2 : 0;
         2: return c[14] ? 0 : c[8] ? 1 :
            !c[9] || c[12] || c[13] ? 0 : c[10] ? 5 : c[11] ? 6 : 0;
         3: return c[14] ? 1 : c[8] || !c[9] ? 0 :
            c[12] ? 5 : c[13] ? 6 : 0;
         4: return c[6] ? 2 : c[7] ? 1 : 0;
         5: return c[6] ? 2 : c[7] ? 0 : 1;
         default: return lk[k-6] ? (ac[k-6] ? 2 : 1) : 0;
      endcase
   endfunction : model

   task automatic chk(input string nm, input logic [31:0] e,
      input logic [31:0] g);
      tests_run++;
      if (g !== e) begin
         failures++;
         $display("[ERR] %s exp %h got %h", nm, e, g);
      end
   endtask : chk

   // one transfer; held until ready is seen at an edge
   task automatic apb(input logic w, input logic [11:0] a,
      input logic [31:0] d, input logic [3:0] s,
      output logic [31:0] rd, output logic er);
      @(posedge I_SYS_CLK);
      I_PSEL <= 1'b1;
      I_PENABLE <= 1'b0;
      I_PWRITE <= w;
      I_PADDR <= a;
      I_PWDATA <= d;
      I_PSTRB <= s;
      @(posedge I_SYS_CLK);
      I_PENABLE <= 1'b1;
      @(posedge I_SYS_CLK);
      while (O_PREADY !== 1'b1) @(posedge I_SYS_CLK);
      rd = O_PRDATA;
      er = O_PSLVERR;
      I_PSEL <= 1'b0;
      I_PENABLE <= 1'b0;
   endtask : apb

   // watch one indicator for exactly one pattern period
   task automatic look(input int k, input int p);
      sel = k;
      @(posedge I_SYS_CLK);
      obs_en <= 1'b1;
      repeat (per_s[p] * T) @(posedge I_SYS_CLK);
      obs_en <= 1'b0;
      #1;
      chk($sformatf("lit%0d", k), 32'(lit_s[p] * T), obs_lit);
      chk($sformatf("rise%0d", k), 32'(ris_s[p]), obs_rises);
   endtask : look

   task automatic finish_test();
      $display("checks %0d failures %0d", tests_run, failures);
      if (failures == 0 && tests_run > 0) begin
         $display("DONE - PASS");
      end else begin
         $display("DONE - FAIL");
      end
      $finish;
   endtask : finish_test

   // hang guard
   always @(posedge I_SYS_CLK) begin
      cyc++;
      if (cyc == LIMIT) begin
         failures++;
         finish_test();
      end
   end

   initial begin
      logic [31:0] rd, d;
      logic [3:0] s;
      logic er;
      repeat (12) @(posedge I_SYS_CLK);
      I_RST <= 1'b0;
      apb(1'b1, 12'h008, 32'hffff_ffff, 4'hf, rd, er);
      chk("wr_unmapped", 32'h1, 32'(er));
      apb(1'b0, 12'h100, 32'h0, 4'h0, rd, er);
      chk("rd_unmapped", 32'h1, 32'(er));
      chk("rd_unmapped_data", 32'h0, rd);
      for (int i = 0; i < 30; i++) begin
         d = (i < dir.size()) ? dir[i] : $random(seed);
         s = (i < dir.size()) ? 4'hf : 4'($random(seed));
         for (int b = 0; b < 4; b++)
            if (s[b]) ctrl_m[8*b +: 8] = d[8*b +: 8];
         ctrl_m = ctrl_m & CTRL_MASK;
         apb(1'b1, ADDR_CTRL, d, s, rd, er);
         chk("wr_err", 32'h0, 32'(er));
         apb(1'b1, ADDR_STAT, ~d, 4'hf, rd, er);
         chk("stat_wr_err", 32'h0, 32'(er));
         apb(1'b0, ADDR_CTRL, 32'h0, 4'h0, rd, er);
         chk("ctrl", ctrl_m, rd);
         I_LINK <= 2'($random(seed));
         I_ACT <= 2'($random(seed));
         repeat (40) @(posedge I_SYS_CLK);
         for (int k = 0; k < 8; k++)
            look(k, model(ctrl_m, I_LINK, I_ACT, k));
         // link pins long settled: status shows link and stretch
         apb(1'b0, ADDR_STAT, 32'h0, 4'h0, rd, er);
         chk("stat_link", 32'(I_LINK), 32'(rd[1:0]));
         chk("stat_act", 32'(I_LINK & I_ACT), 32'(rd[3:2]));
         chk("stat_rsv", 32'h0, 32'(rd[31:10]));
      end
      finish_test();
   end
endmodule : tb_top
